// ---- logic/hrpc_pkg.sv ----
// Purpose: constants and carriers shared by the hibernation power controller
// Assumes: 32-bit classic wishbone, byte addresses
// Notes: control bit order is fixed by the packed struct below

package hrpc_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [8:0] ADDR_COUNT = 9'h000;
  localparam logic [8:0] ADDR_MATCH_A = 9'h004;
  localparam logic [8:0] ADDR_MATCH_B = 9'h008;
  localparam logic [8:0] ADDR_LOAD = 9'h00c;
  localparam logic [8:0] ADDR_CTL = 9'h010;
  localparam logic [8:0] ADDR_MASK = 9'h014;
  localparam logic [8:0] ADDR_RAW = 9'h018;
  localparam logic [8:0] ADDR_MASKED = 9'h01c;
  localparam logic [8:0] ADDR_CLEAR = 9'h020;
  localparam logic [8:0] ADDR_TRIM = 9'h024;
  localparam logic [8:0] ADDR_DATA_LO = 9'h030;
  localparam logic [8:0] ADDR_DATA_HI = 9'h12c;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [31:0] MATCH_RST = 32'hffffffff;
  localparam logic [31:0] LOAD_RST = 32'hffffffff;
  localparam logic [15:0] TRIM_RST = 16'h7fff;
  localparam logic [15:0] PREDIV_NOMINAL = 16'h7fff;
  localparam logic [5:0] TRIM_SECOND = 6'h3f;
  localparam logic [6:0] XTAL_DIV_LAST = 7'h7f;
  localparam int DATA_WORDS = 64;

  // ****************************************
  // carriers
  // ****************************************
  // control register, bit 0 upward: count_en, sleep_req, clk_sel (bit 2), ...
  typedef struct packed {
    logic lowbatt_abort_enable;
    logic slow_clk_enable;
    logic lowbatt_detect_enable;
    logic pin_wake_enable;
    logic match_wake_enable;
    logic slow_clk_select_bit;
    logic sleep_request;
    logic seconds_count_enable;
  } hrpc_ctl_s;

  // event bits as seen in raw, mask, masked and clear views
  typedef struct packed {
    logic pin_wake;
    logic lowbatt_flag;
    logic match_b;
    logic match_a;
  } hrpc_evt_s;

  typedef enum {
    HRPC_AWAKE,
    HRPC_ASLEEP
  } hrpc_state_e;

endpackage

// ---- logic/hrpc_power_ctrl.sv ----
// Purpose: hibernation power controller with seconds counter and retained words
// Assumes: inputs synchronous to clk_i; slow reference sampled as a level
// Notes: the slow reference is oversampled, so no second clock domain exists

`timescale 1ns/1ps

module hrpc_power_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic slow_ref_i,
  input wire logic wake_n_i,
  input wire logic lowbatt_i,
  output logic regulator_off_n_o,
  output logic irq_o
);
  import hrpc_pkg::*;

  // ****************************************
  // bus decode
  // ****************************************
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic req, wr;
  logic [31:0] be_mask, wval;
  logic in_data;
  logic [5:0] data_idx;
  logic [6:0] data_off;

  // byte lanes expand to a bit mask
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign be_mask[8*g +: 8] = {8{wb_sel_i[g]}};
  end

  // request is taken once; ack drops the cycle after it is given
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  assign in_data = (wb_adr_i >= ADDR_DATA_LO) && (wb_adr_i <= ADDR_DATA_HI);
  assign data_off = wb_adr_i[8:2] - ADDR_DATA_LO[8:2];
  assign data_idx = data_off[5:0];

  // ****************************************
  // registers
  // ****************************************
  hrpc_ctl_s ctl_q, ctl_d;
  hrpc_evt_s mask_q, mask_d, raw_q, raw_d, evt_set;
  logic [31:0] match_a_q, match_a_d, match_b_q, match_b_d, load_q, load_d;
  logic [15:0] trim_q, trim_d;
  logic [31:0] mem_q [DATA_WORDS];
  hrpc_state_e state_q, state_d;
  logic off_n_q, off_n_d, irq_q, irq_d;
  logic load_wr, clear_wr;
  hrpc_evt_s clear_bits;

  // ****************************************
  // synchronisers and slow time base
  // ****************************************
  logic ref_s1_q, ref_s2_q, ref_s3_q, wake_s1_q, wake_s2_q, wake_s3_q, lb_s1_q, lb_s2_q;
  logic [6:0] div_q, div_d;
  logic [15:0] pre_q, pre_d;
  logic [5:0] phase_q, phase_d;
  logic [31:0] count_q, count_d;
  logic ref_rise, slow_tick, sec_tick, wake_edge, lb_low;

  // first stages feed only the second stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      wake_s1_q <= 1'b1;
      wake_s2_q <= 1'b1;
      wake_s3_q <= 1'b1;
      lb_s1_q <= 1'b0;
      lb_s2_q <= 1'b0;
    end else begin
      ref_s1_q <= slow_ref_i;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      wake_s1_q <= wake_n_i;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
      lb_s1_q <= lowbatt_i;
      lb_s2_q <= lb_s1_q;
    end
  end

  // edge detection looks only at synchronised stages
  assign ref_rise = ref_s2_q & ~ref_s3_q;
  assign wake_edge = ~wake_s2_q & wake_s3_q;
  assign lb_low = lb_s2_q; // comparator output below 2.35 V, synchronised
  assign load_wr = wr && (wb_adr_i == ADDR_LOAD);
  assign clear_wr = wr && (wb_adr_i == ADDR_CLEAR);
  assign wval = wb_dat_i & be_mask;
  assign clear_bits = wval[3:0];

  // slow tick: crystal path divided, oscillator path direct
  always_comb begin
    div_d = div_q;
    slow_tick = 1'b0;
    if (ctl_q.slow_clk_enable && ref_rise) begin
      if (ctl_q.slow_clk_select_bit) begin
        slow_tick = 1'b1;
      end else begin
        div_d = div_q + 7'h01;
        slow_tick = (div_q == XTAL_DIV_LAST);
      end
    end
  end

  // predivider counts down; trimmed reload one second in 64
  always_comb begin
    pre_d = pre_q;
    phase_d = phase_q;
    count_d = count_q;
    sec_tick = 1'b0;
    if (slow_tick) begin
      if (pre_q == 16'h0000) begin
        sec_tick = 1'b1;
        phase_d = phase_q + 6'h01;
        // a longer reload stretches the second, slowing the count
        pre_d = (phase_q == TRIM_SECOND) ? trim_q : PREDIV_NOMINAL;
      end else begin
        pre_d = pre_q - 16'h0001;
      end
    end
    if (sec_tick && ctl_q.seconds_count_enable) begin
      count_d = count_q + 32'h00000001;
    end
    if (load_wr) begin
      count_d = (load_q & ~be_mask) | wval;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 7'h00;
      pre_q <= PREDIV_NOMINAL;
      phase_q <= 6'h00;
      count_q <= 32'h00000000;
    end else begin
      div_q <= div_d;
      pre_q <= pre_d;
      phase_q <= phase_d;
      count_q <= count_d;
    end
  end

  // ****************************************
  // events, power state and registers
  // ****************************************
  // match only when the counter steps onto the value, not on a load
  always_comb begin
    evt_set = '0;
    evt_set.match_a = sec_tick && ctl_q.seconds_count_enable && !load_wr && (count_d == match_a_q);
    evt_set.match_b = sec_tick && ctl_q.seconds_count_enable && !load_wr && (count_d == match_b_q);
    evt_set.pin_wake = wake_edge;
    // battery is not measured while the regulator is off
    evt_set.lowbatt_flag = ctl_q.lowbatt_detect_enable && lb_low && (state_q == HRPC_AWAKE);
  end

  always_comb begin
    ctl_d = ctl_q;
    mask_d = mask_q;
    match_a_d = match_a_q;
    match_b_d = match_b_q;
    load_d = load_q;
    trim_d = trim_q;
    state_d = state_q;
    if (wr) begin
      case (wb_adr_i)
        ADDR_MATCH_A: match_a_d = (match_a_q & ~be_mask) | wval;
        ADDR_MATCH_B: match_b_d = (match_b_q & ~be_mask) | wval;
        ADDR_LOAD: load_d = (load_q & ~be_mask) | wval;
        ADDR_CTL: ctl_d = (ctl_q & ~be_mask[7:0]) | wval[7:0];
        ADDR_MASK: mask_d = (mask_q & ~be_mask[3:0]) | wval[3:0];
        ADDR_TRIM: trim_d = (trim_q & ~be_mask[15:0]) | wval[15:0];
        default: ;
      endcase
    end
    // set wins over clear so no event is lost
    raw_d = (raw_q & ~(clear_wr ? clear_bits : 4'h0)) | evt_set;
    case (state_q)
      HRPC_AWAKE: begin
        if (ctl_q.sleep_request) begin
          // without a wake source the request would never end; it is dropped
          if (!(ctl_q.pin_wake_enable || ctl_q.match_wake_enable)) begin
            ctl_d.sleep_request = 1'b0;
          end else if (ctl_q.lowbatt_abort_enable && ctl_q.lowbatt_detect_enable && lb_low) begin
            ctl_d.sleep_request = 1'b0;
          end else begin
            state_d = HRPC_ASLEEP;
          end
        end
      end
      HRPC_ASLEEP: begin
        if ((ctl_q.pin_wake_enable && evt_set.pin_wake) ||
            (ctl_q.match_wake_enable && (evt_set.match_a || evt_set.match_b))) begin
          state_d = HRPC_AWAKE;
          ctl_d.sleep_request = 1'b0;
        end
      end
      default: state_d = HRPC_AWAKE;
    endcase
    off_n_d = (state_d != HRPC_ASLEEP);
    irq_d = |(raw_d & mask_d);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= '0;
      mask_q <= '0;
      raw_q <= '0;
      match_a_q <= MATCH_RST;
      match_b_q <= MATCH_RST;
      load_q <= LOAD_RST;
      trim_q <= TRIM_RST;
      state_q <= HRPC_AWAKE;
      off_n_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      mask_q <= mask_d;
      raw_q <= raw_d;
      match_a_q <= match_a_d;
      match_b_q <= match_b_d;
      load_q <= load_d;
      trim_q <= trim_d;
      state_q <= state_d;
      off_n_q <= off_n_d;
      irq_q <= irq_d;
    end
  end

  // retained words have no reset: their content must survive every power cut
  always_ff @(posedge clk_i) begin
    if (wr && in_data) begin
      mem_q[data_idx] <= (mem_q[data_idx] & ~be_mask) | wval;
    end
  end

  // ****************************************
  // read path and answer
  // ****************************************
  // unmapped addresses answer with zero rather than stalling the bus
  always_comb begin
    rdat_d = rdat_q;
    ack_d = req;
    if (req && !wb_we_i) begin
      rdat_d = 32'h00000000;
      if (in_data) begin
        rdat_d = mem_q[data_idx];
      end else begin
        case (wb_adr_i)
          ADDR_COUNT: rdat_d = count_q;
          ADDR_MATCH_A: rdat_d = match_a_q;
          ADDR_MATCH_B: rdat_d = match_b_q;
          ADDR_LOAD: rdat_d = load_q;
          ADDR_CTL: rdat_d[7:0] = ctl_q;
          ADDR_MASK: rdat_d[3:0] = mask_q;
          ADDR_RAW: rdat_d[3:0] = raw_q;
          ADDR_MASKED: rdat_d[3:0] = raw_q & mask_q;
          ADDR_TRIM: rdat_d[15:0] = trim_q;
          default: rdat_d = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign regulator_off_n_o = off_n_q;
  assign irq_o = irq_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_off_tracks_state;
    (state_q == HRPC_ASLEEP) == !regulator_off_n_o;
  endproperty
  a_off_tracks_state: assert property (p_off_tracks_state) else $error("regulator enable disagrees with state");
  property p_pin_wakes;
    (state_q == HRPC_ASLEEP) && ctl_q.pin_wake_enable && wake_edge |=> regulator_off_n_o && !ctl_q.sleep_request;
  endproperty
  a_pin_wakes: assert property (p_pin_wakes) else $error("wake pin did not restore power");
  property p_abort_lowbatt;
    (state_q == HRPC_AWAKE) && ctl_q.lowbatt_abort_enable && ctl_q.lowbatt_detect_enable && lb_low
      |=> regulator_off_n_o;
  endproperty
  a_abort_lowbatt: assert property (p_abort_lowbatt) else $error("hibernation entered on low battery");
  property p_count_hold;
    !ctl_q.seconds_count_enable && !load_wr |=> $stable(count_q);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved while disabled");
  property p_load;
    load_wr && (wb_sel_i == 4'hf) |=> count_q == $past(wb_dat_i);
  endproperty
  a_load: assert property (p_load) else $error("load did not set counter");
  property p_clear;
    clear_wr && wval[0] && !evt_set.match_a |=> !raw_q.match_a;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not clear event");
  property p_irq_or;
    irq_o == |(raw_q & mask_q);
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("interrupt line not OR of masked events");
  property p_trim_reload;
    slow_tick && (pre_q == 16'h0000) && (phase_q == TRIM_SECOND) |=> pre_q == $past(trim_q);
  endproperty
  a_trim_reload: assert property (p_trim_reload) else $error("trim not used in its second");
  property p_no_measure_asleep;
    (state_q == HRPC_ASLEEP) && !raw_q.lowbatt_flag |=> !raw_q.lowbatt_flag;
  endproperty
  a_no_measure_asleep: assert property (p_no_measure_asleep) else $error("battery measured while asleep");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over two cycles");

endmodule

// ---- verif/hrpc_host_model.sv ----
// Purpose: far side of the power controller: regulator, wake button, battery comparator, slow oscillator
// Assumes: one system clock; the slow oscillator toggles every cycle so one second fits in the run
// Notes: the oscillator runs free, so no crystal settling wait is needed

`timescale 1ns/1ps

module hrpc_host_model (
  input wire logic clk_i,
  input wire logic regulator_off_n_i,
  input wire logic press_i,
  input wire logic batt_low_i,
  output logic wake_n_o,
  output logic lowbatt_o,
  output logic slow_ref_o,
  output logic rail_up_o
);
  logic ref_q = 1'b0;

  // the pin has a weak pull-up, so a released button reads high
  assign wake_n_o = press_i ? 1'b0 : 1'b1;
  // comparator output follows the battery level directly
  assign lowbatt_o = batt_low_i;
  // regulator powers the rail while its enable is high
  assign rail_up_o = regulator_off_n_i;

  // free-running oscillator at half the system clock, no settle time
  always_ff @(posedge clk_i) begin
    ref_q <= ~ref_q;
  end
  assign slow_ref_o = ref_q;
endmodule

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench for the hibernation power controller
// Assumes: classic wishbone master, design answers with a one-cycle ack
// Notes: one full second (32768 slow ticks, two cycles each) is run once after a mid-run reset

`timescale 1ns/1ps

module tb_top;
  import hrpc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [8:0] adr = 9'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, off_n, irq, wake_n, lowbatt, slow_ref, rail_up;
  logic press = 1'b0;
  logic batt_low = 1'b0;
  int n_fail = 0;
  int samples_checked = 0;

  always #5 clk_i = ~clk_i;

  hrpc_power_ctrl hrpc_power_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .slow_ref_i(slow_ref), .wake_n_i(wake_n), .lowbatt_i(lowbatt), .regulator_off_n_o(off_n), .irq_o(irq));

  hrpc_host_model hrpc_host_model_inst (.clk_i(clk_i), .regulator_off_n_i(off_n), .press_i(press),
    .batt_low_i(batt_low), .wake_n_o(wake_n), .lowbatt_o(lowbatt), .slow_ref_o(slow_ref), .rail_up_o(rail_up));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; request held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 64) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 64) chk("ack", 32'h0, 32'h1);
    r = rdat;
    // released for at least one cycle before the next request
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, 4'hf, r);
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, 4'hf, r);
    chk($sformatf("addr %h", a), r, exp);
  endtask

  // regulator enable checked once wake or sleep has had time to land
  task automatic off_is(input logic exp);
    repeat (10) @(posedge clk_i);
    chk("regulator_off_n", {31'h0, off_n}, {31'h0, exp});
    chk("rail_up", {31'h0, rail_up}, {31'h0, exp});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_reset;
    logic [8:0] ra [10] = '{ADDR_COUNT, ADDR_MATCH_A, ADDR_MATCH_B, ADDR_LOAD, ADDR_CTL, ADDR_MASK,
                            ADDR_RAW, ADDR_MASKED, ADDR_TRIM, 9'h028};
    logic [31:0] rv [10] = '{32'h0, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h0, 32'h0,
                             32'h0, 32'h0, 32'h00007fff, 32'h0};
    chk("irq", {31'h0, irq}, 32'h0);
    off_is(1'b1);
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
  endtask

  task automatic s_regs;
    logic [31:0] r;
    wr(ADDR_MATCH_A, 32'h12345678);
    rd(ADDR_MATCH_A, 32'h12345678);
    wb(1'b1, ADDR_MATCH_B, 32'haabbccdd, 4'h1, r);
    rd(ADDR_MATCH_B, 32'hffffffdd);
    wr(ADDR_LOAD, 32'h00001000);
    wr(ADDR_COUNT, 32'h00000005);
    repeat (40) @(posedge clk_i);
    rd(ADDR_COUNT, 32'h00001000);
    wr(ADDR_TRIM, 32'h00008001);
    rd(ADDR_TRIM, 32'h00008001);
    wr(ADDR_CTL, 32'h00000044);
    rd(ADDR_CTL, 32'h00000044);
    wr(9'h028, 32'h5a5a5a5a);
    rd(9'h028, 32'h0);
    // fill every word first so an aliased address shows up on read-back
    for (int i = 0; i < DATA_WORDS; i++) wr(ADDR_DATA_LO + 9'(i * 4), 32'hc0de0000 | i);
    for (int i = 0; i < DATA_WORDS; i++) rd(ADDR_DATA_LO + 9'(i * 4), 32'hc0de0000 | i);
  endtask

  task automatic s_refuse;
    wr(ADDR_CTL, 32'h00000042);
    off_is(1'b1);
    rd(ADDR_CTL, 32'h00000040);
    wr(ADDR_CTL, 32'h000000e4);
    batt_low <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(ADDR_RAW, 32'h00000004);
    wr(ADDR_CTL, 32'h000000f6);
    off_is(1'b1);
    rd(ADDR_CTL, 32'h000000f4);
    batt_low <= 1'b0;
    wr(ADDR_CTL, 32'h00000044);
    wr(ADDR_CLEAR, 32'h0000000f);
    rd(ADDR_RAW, 32'h0);
  endtask

  task automatic s_sleep_pin;
    // software enables the pin wake in the same write that asks for sleep
    wr(ADDR_CTL, 32'h00000076);
    off_is(1'b0);
    batt_low <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(ADDR_RAW, 32'h0);
    press <= 1'b1;
    off_is(1'b1);
    press <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(ADDR_RAW, 32'h0000000c);
    rd(ADDR_CTL, 32'h00000074);
    batt_low <= 1'b0;
    off_is(1'b1);
  endtask

  task automatic s_irq;
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(ADDR_MASKED, 32'h0);
    wr(ADDR_MASK, 32'h00000008);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(ADDR_MASKED, 32'h00000008);
    rd(ADDR_CLEAR, 32'h0);
    wr(ADDR_CLEAR, 32'h00000004);
    rd(ADDR_RAW, 32'h00000008);
    wr(ADDR_CLEAR, 32'h00000008);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(ADDR_RAW, 32'h0);
  endtask

  // mid-run reset restarts the predivider, so the first second has a known length
  task automatic s_match;
    int n;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("irq", {31'h0, irq}, 32'h0);
    chk("regulator_off_n", {31'h0, off_n}, 32'h1);
    rd(ADDR_CTL, 32'h0);
    rd(ADDR_TRIM, 32'h00007fff);
    rd(ADDR_DATA_LO, 32'hc0de0000);
    wr(ADDR_MATCH_A, 32'h00000101);
    wr(ADDR_LOAD, 32'h00000100);
    rd(ADDR_COUNT, 32'h00000100);
    wr(ADDR_MASK, 32'h00000001);
    // match wake, clock on, oscillator path, counting, sleep
    wr(ADDR_CTL, 32'h0000004f);
    off_is(1'b0);
    n = 0;
    while (off_n !== 1'b1 && n < 70000) begin
      @(posedge clk_i);
      n++;
    end
    // one second is 0x8000 slow ticks of two cycles, less the cycles spent above
    chk("second cycles", {31'h0, (n > 65400 && n < 65600)}, 32'h1);
    off_is(1'b1);
    rd(ADDR_COUNT, 32'h00000101);
    rd(ADDR_RAW, 32'h00000001);
    rd(ADDR_MASKED, 32'h00000001);
    rd(ADDR_CTL, 32'h0000004d);
    chk("irq", {31'h0, irq}, 32'h1);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset;
    s_regs;
    s_refuse;
    s_sleep_pin;
    s_irq;
    s_match;
    finish_test;
  end

  // about 66000 cycles are expected, so 80000 means a hang
  initial begin
    #800000;
    n_fail++;
    finish_test;
  end
endmodule
